// ---- logic/exec_state_pkg.sv ----
// Purpose: Shared constants for the execution-state bits of the status word.
// Assumes: 32-bit status word; execution state is eight bits split over two places.
// Notes:   The combined field is ordered {hi[26:25] -> bits 1:0, lo[15:10] -> bits 7:2}.
package exec_state_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned FIELD_W     = 8;
  localparam int unsigned REG_ID_W    = 4;
  // Positions inside the status word.
  localparam int unsigned HI_MSB      = 26;
  localparam int unsigned HI_LSB      = 25;
  localparam int unsigned ISA_BIT     = 24;
  localparam int unsigned LO_MSB      = 15;
  localparam int unsigned LO_LSB      = 10;
  localparam int unsigned REG_MSB     = 15;
  localparam int unsigned REG_LSB     = 12;
  localparam int unsigned SAT_BIT     = 27;
  // Positions inside the combined eight-bit field.
  localparam int unsigned F_HI_MSB    = 1;
  localparam int unsigned F_LO_LSB    = 2;
  localparam int unsigned F_REG_LSB   = 4;
  localparam int unsigned F_COND_LSB  = 4;
  // Reset values.
  localparam logic              ISA_RESET   = 1'h1;
  localparam logic [7:0]        FIELD_RESET = 8'h00;
  localparam logic [3:0]        NIBBLE_ZERO = 4'h0;
  localparam logic [2:0]        TAIL_ZERO   = 3'h0;
  localparam logic [WORD_W-1:0] WORD_ZERO   = 32'h0000_0000;
endpackage

// ---- logic/cond_block_if.sv ----
// Purpose: Carries the conditional-block state between controller and sequencer.
// Assumes: Single clock domain; all strobes are one-cycle pulses.
// Notes:   The controller holds advance off under load or clear; load and clear can coincide, and clear wins.
`timescale 1ns/10ps
`default_nettype none
interface cond_block_if;
  logic       load;      // Start a new conditional block.
  logic       clear;     // Abandon the block.
  logic       advance;   // One instruction of the block retired.
  logic [7:0] load_val;  // State to load.
  logic [7:0] state;     // Current state.
  logic       active;    // A block is in progress.
  modport ctrl (output load, output clear, output advance, output load_val,
                input state, input active);
  modport seq  (input load, input clear, input advance, input load_val,
                output state, output active);
endinterface
`default_nettype wire

// ---- logic/cond_block_seq.sv ----
// Purpose: Holds and steps the conditional-block execution state.
// Assumes: Advance pulses once per retired instruction inside the block.
// Notes:   Block ends on a step taken while the low three bits are zero.
`timescale 1ns/10ps
`default_nettype none
module cond_block_seq
  import exec_state_pkg::*;
(
  input  wire logic  i_mclk,    // Core clock.
  input  wire logic  i_resetn,  // Asynchronous reset, active low.
  cond_block_if.seq  cb         // Conditional-block carrier.
);
  logic [7:0] state_q;
  logic [7:0] state_d;
  logic [7:0] stepped;
  logic       done;

  // The mask shifts left each step; an empty tail ends the block.
  assign done    = (state_q[2:0] == TAIL_ZERO);
  assign stepped = done ? FIELD_RESET : {state_q[7:5], state_q[3:0], 1'b0};
  assign state_d = cb.clear ? FIELD_RESET :
                   cb.load ? cb.load_val :
                   cb.advance ? stepped : state_q;
  assign cb.state  = state_q;
  assign cb.active = (state_q[3:0] != NIBBLE_ZERO);

  // State register.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      state_q <= FIELD_RESET;
    else
      state_q <= state_d;
  end
endmodule
`default_nettype wire

// ---- logic/exec_state_ctrl.sv ----
// Purpose: Execution-state bits of the status word inside the core.
// Assumes: All event inputs come from core logic on i_mclk and are one-cycle pulses.
// Notes:   Exception entry wins over return, which wins over branches.
//          Entry clears the field; stacking has already copied it by then.
`timescale 1ns/10ps
`default_nettype none
module exec_state_ctrl
  import exec_state_pkg::*;
(
  input  wire logic              i_mclk,          // Core clock, 200 MHz.
  input  wire logic              i_resetn,        // Asynchronous reset, active low.
  input  wire logic              i_vector_load,   // Vector fetched at reset or entry.
  input  wire logic              i_vector_bit0,   // Bit 0 of the fetched vector.
  input  wire logic              i_exc_entry,     // Exception entry.
  input  wire logic              i_exc_return,    // Exception return.
  input  wire logic [WORD_W-1:0] i_stacked_word,  // Status word popped on return.
  input  wire logic              i_branch_xchg,   // Exchange branch or pop to pc.
  input  wire logic              i_target_bit0,   // Bit 0 of the branch target.
  input  wire logic              i_xfer_suspend,  // Multi-register transfer interrupted.
  input  wire logic [3:0]        i_xfer_next_reg, // Next register of that transfer.
  input  wire logic              i_xfer_done,     // Resumed transfer has finished.
  input  wire logic              i_cond_start,    // Conditional-block instruction.
  input  wire logic [7:0]        i_cond_state,    // Condition and mask it sets up.
  input  wire logic              i_instr_retire,  // An instruction retired.
  input  wire logic              i_exec_attempt,  // An instruction is about to run.
  input  wire logic              i_sat_set,       // Saturation occurred.
  input  wire logic              i_move_wr,       // Special-register move write.
  input  wire logic [WORD_W-1:0] i_move_wdata,    // Data of that write.
  output logic [WORD_W-1:0]      o_move_rdata,    // Special-register move read data.
  output logic [WORD_W-1:0]      o_stack_word,    // Execution bits for stacking.
  output logic                   o_isa_state,     // Instruction-set state bit.
  output logic                   o_sat_flag,      // Sticky saturation flag.
  output logic                   o_resume_pending, // A suspended transfer waits.
  output logic [3:0]             o_resume_reg,    // Register to resume from.
  output logic                   o_cond_active,   // Conditional block in progress.
  output logic [3:0]             o_cond_code,     // Condition of the current instruction.
  output logic                   o_isa_fault      // One-cycle fault on illegal state.
);
  cond_block_if cb ();

  // Instruction-set bit.
  logic       isa_q;
  logic       isa_d;
  // Suspended transfer flag and the register it resumes from.
  logic       xfer_q;
  logic       xfer_d;
  logic [3:0] reg_q;
  logic [3:0] reg_d;
  logic       xfer_drop;
  // Sticky saturation flag and the registered fault pulse.
  logic       sat_q;
  logic       fault_q;
  logic       fault_d;
  // Live field and the field popped on return.
  logic [7:0] field;
  logic [7:0] stacked_field;
  logic [3:0] stacked_reg;
  logic       stacked_is_xfer;
  logic       restore_cond;
  logic       return_xfer;

  // Builds the combined field from a full status word.
  function automatic logic [7:0] field_of(input logic [WORD_W-1:0] w);
    field_of = {w[LO_MSB:LO_LSB], w[HI_MSB:HI_LSB]};
  endfunction

  // Places the combined field and the instruction-set bit into a word.
  // Every other position stays zero, so stacking never leaks stray bits.
  function automatic logic [WORD_W-1:0] word_of(input logic [7:0] f, input logic isa);
    logic [WORD_W-1:0] w;
    w = WORD_ZERO;
    w[HI_MSB:HI_LSB] = f[F_HI_MSB:0];
    w[ISA_BIT]       = isa;
    w[LO_MSB:LO_LSB] = f[FIELD_W-1:F_LO_LSB];
    word_of = w;
  endfunction

  cond_block_seq u_seq (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .cb       (cb)
  );

  // A stacked field with an empty mask but a register number is transfer state.
  // A transfer suspended before register zero stacks as an all-zero field and
  // so returns as plain execution; the core must restart such a transfer.
  assign stacked_field   = field_of(i_stacked_word);
  assign stacked_reg     = stacked_field[FIELD_W-1:F_REG_LSB];
  assign stacked_is_xfer = (stacked_field[3:0] == NIBBLE_ZERO)
                           && (stacked_reg != NIBBLE_ZERO);
  assign return_xfer     = i_exc_return && !i_exc_entry && stacked_is_xfer;
  assign restore_cond    = i_exc_return && !i_exc_entry && !stacked_is_xfer;

  // Completion of a resumed transfer, or a new block, ends the transfer state.
  assign xfer_drop = i_xfer_done || i_cond_start;

  // Control of the conditional-block sequencer; transfer state excludes it.
  assign cb.load     = (i_cond_start && !i_exc_entry) || restore_cond;
  assign cb.load_val = restore_cond ? stacked_field : i_cond_state;
  assign cb.clear    = i_exc_entry || i_xfer_suspend || return_xfer;
  assign cb.advance  = i_instr_retire && !cb.load && !cb.clear;

  // Combined field: transfer state keeps the high pair and bits 11:10 zero.
  assign field = xfer_q ? {reg_q, NIBBLE_ZERO} : cb.state;

  // Instruction-set bit sources in priority order; the core should never raise
  // two at once, and the order only keeps the bit defined if it does.
  always_comb
  begin
    isa_d = isa_q;
    if (i_vector_load)
      isa_d = i_vector_bit0;
    else if (i_exc_return)
      isa_d = i_stacked_word[ISA_BIT];
    else if (i_branch_xchg)
      isa_d = i_target_bit0;
  end

  // Transfer state: entry clears it after stacking, a suspend records it,
  // a return restores it from the popped word.
  always_comb
  begin
    xfer_d = xfer_q;
    reg_d  = reg_q;
    if (i_exc_entry)
      xfer_d = 1'b0;
    else if (i_xfer_suspend)
    begin
      xfer_d = 1'b1;
      reg_d  = i_xfer_next_reg;
    end
    else if (i_exc_return)
    begin
      xfer_d = stacked_is_xfer;
      reg_d  = stacked_reg;
    end
    else if (xfer_drop)
      xfer_d = 1'b0;
  end

  // An attempt to run with the bit clear is reported one cycle later; lockup
  // handling stays with the core.
  assign fault_d = i_exec_attempt && !isa_q;

  // Instruction-set bit; it leaves reset set.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      isa_q <= ISA_RESET;
    else
      isa_q <= isa_d;
  end

  // Transfer flag and the register it resumes from.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      xfer_q <= 1'b0;
      reg_q  <= NIBBLE_ZERO;
    end
    else
    begin
      xfer_q <= xfer_d;
      reg_q  <= reg_d;
    end
  end

  // Fault pulse register.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      fault_q <= 1'b0;
    else
      fault_q <= fault_d;
  end

  // Saturation flag: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      sat_q <= 1'b0;
    else if (i_sat_set)
      sat_q <= 1'b1;
    else if (i_move_wr)
      sat_q <= i_move_wdata[SAT_BIT];
  end

  // Move reads show only the saturation flag; execution and reserved bits are zero.
  always_comb
  begin
    o_move_rdata          = WORD_ZERO;
    o_move_rdata[SAT_BIT] = sat_q;
  end

  // The stacked view carries the real execution state.
  assign o_stack_word     = word_of(field, isa_q);
  assign o_isa_state      = isa_q;
  assign o_sat_flag       = sat_q;
  assign o_resume_pending = xfer_q;
  assign o_resume_reg     = reg_q;

  // Block status is hidden while a suspended transfer owns the field.
  assign o_cond_active    = cb.active && !xfer_q;
  assign o_cond_code      = cb.state[FIELD_W-1:F_COND_LSB];
  assign o_isa_fault      = fault_q;
endmodule
`default_nettype wire

// ---- testbench/exec_state_asserts.sv ----
// Purpose: Assertions on the execution-state ports of the status word.
// Assumes: One clock domain; event inputs are one-cycle pulses.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
`default_nettype none
module exec_state_asserts
  import exec_state_pkg::*;
(
  input wire logic              i_mclk,           // Core clock.
  input wire logic              i_resetn,         // Asynchronous reset, active low.
  input wire logic              i_vector_load,    // Vector fetched.
  input wire logic              i_vector_bit0,    // Bit 0 of that vector.
  input wire logic              i_exc_return,     // Exception return.
  input wire logic              i_exc_entry,      // Exception entry.
  input wire logic              i_branch_xchg,    // Exchange branch.
  input wire logic              i_target_bit0,    // Bit 0 of the target.
  input wire logic              i_xfer_suspend,   // Transfer interrupted.
  input wire logic              i_cond_start,     // Conditional block begins.
  input wire logic              i_exec_attempt,   // Instruction about to run.
  input wire logic              i_sat_set,        // Saturation occurred.
  input wire logic              i_move_wr,        // Move write.
  input wire logic              o_isa_state,      // Instruction-set bit.
  input wire logic              o_sat_flag,       // Saturation flag.
  input wire logic              o_resume_pending, // Suspended transfer waits.
  input wire logic              o_isa_fault,      // Fault pulse.
  input wire logic [3:0]        i_xfer_next_reg,  // Next register.
  input wire logic [3:0]        o_resume_reg,     // Resume register.
  input wire logic [WORD_W-1:0] o_move_rdata,     // Move read data.
  input wire logic [WORD_W-1:0] o_stack_word      // Stacked execution bits.
);
  // All checks share the core clock and its reset.
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Properties tie an output to the event that caused it; reserved_zero_a, move_view_a and xfer_zero_a check invariants.
  reset_value_a: assert property (
    $rose(i_resetn) |-> o_stack_word == 32'h0100_0000) else $error("bad reset value");
  reserved_zero_a: assert property (
    (o_stack_word & 32'hf8ff_03ff) == 32'h0) else $error("reserved bits set");
  move_view_a: assert property (
    o_move_rdata == {4'h0, o_sat_flag, 27'h0}) else $error("move read shows state");
  xfer_record_a: assert property (
    i_xfer_suspend && !i_exc_entry && !i_cond_start && !i_exc_return |=> o_resume_pending
    && o_resume_reg == $past(i_xfer_next_reg) && o_stack_word[15:12] == $past(i_xfer_next_reg))
    else $error("transfer register lost");
  xfer_zero_a: assert property (
    o_resume_pending |-> o_stack_word[26:25] == 2'h0 && o_stack_word[11:10] == 2'h0)
    else $error("transfer state not clean");
  sat_hold_a: assert property (
    i_sat_set || (o_sat_flag && !i_move_wr) |=> o_sat_flag) else $error("flag dropped");
  isa_branch_a: assert property (
    i_branch_xchg && !i_vector_load && !i_exc_return |=> o_isa_state == $past(i_target_bit0))
    else $error("branch bit wrong");
  isa_vector_a: assert property (
    i_vector_load |=> o_isa_state == $past(i_vector_bit0)) else $error("vector bit wrong");
  fault_cause_a: assert property (
    o_isa_fault |-> $past(i_exec_attempt) && !$past(o_isa_state)) else $error("stray fault");
  fault_raise_a: assert property (
    i_exec_attempt && !o_isa_state |=> o_isa_fault) else $error("fault missing");
  // Main scenarios reached.
  cover property (i_xfer_suspend ##1 o_resume_pending);
  cover property (o_isa_fault);
  cover property (i_sat_set ##1 o_sat_flag);
endmodule
bind exec_state_ctrl exec_state_asserts u_asserts (.i_mclk, .i_resetn, .i_vector_load,
  .i_vector_bit0, .i_exc_return, .i_exc_entry, .i_branch_xchg, .i_target_bit0,
  .i_xfer_suspend, .i_cond_start, .i_exec_attempt, .i_sat_set, .i_move_wr, .o_isa_state,
  .o_sat_flag, .o_resume_pending, .o_isa_fault, .i_xfer_next_reg, .o_resume_reg,
  .o_move_rdata, .o_stack_word);
`default_nettype wire

// ---- testbench/tb_execution_state_status_bits.sv ----
// Purpose: Self-checking bench for the execution-state bits.
// Assumes: Event pulses are launched 1 ns after a rising edge.
// Notes:   Outputs are sampled 1 ns after the edge that takes each pulse.
`timescale 1ns/10ps
`default_nettype none
module tb_execution_state_status_bits;
  import exec_state_pkg::*;
  localparam int VEC = 0, ENT = 1, RET = 2, BXC = 3, SUS = 4, DON = 5;
  localparam int CST = 6, RTR = 7, EXA = 8, SAT = 9, MWR = 10;
  logic              i_mclk, i_resetn, i_vector_bit0, i_target_bit0;
  logic [10:0]       p;
  logic [3:0]        i_xfer_next_reg, o_resume_reg, o_cond_code;
  logic [7:0]        i_cond_state;
  logic [WORD_W-1:0] i_stacked_word, i_move_wdata, o_move_rdata, o_stack_word;
  logic              o_isa_state, o_sat_flag, o_resume_pending, o_cond_active, o_isa_fault;
  int                error_cnt = 0;
  int                checks_done = 0;
  // Design under test; event pulses come from the vector p.
  exec_state_ctrl dut (.i_mclk, .i_resetn, .i_vector_load(p[VEC]), .i_vector_bit0,
    .i_exc_entry(p[ENT]), .i_exc_return(p[RET]), .i_stacked_word, .i_branch_xchg(p[BXC]),
    .i_target_bit0, .i_xfer_suspend(p[SUS]), .i_xfer_next_reg, .i_xfer_done(p[DON]),
    .i_cond_start(p[CST]), .i_cond_state, .i_instr_retire(p[RTR]), .i_exec_attempt(p[EXA]),
    .i_sat_set(p[SAT]), .i_move_wr(p[MWR]), .i_move_wdata, .o_move_rdata, .o_stack_word,
    .o_isa_state, .o_sat_flag, .o_resume_pending, .o_resume_reg, .o_cond_active,
    .o_cond_code, .o_isa_fault);
  function automatic logic [10:0] b(input int i);
    return 11'h1 << i;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // Holds the given pulses for exactly one taking edge.
  task automatic fire(input logic [10:0] v);
    p = v;
    cyc(1);
    p = '0;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Core clock, 5 ns period.
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Cuts a hung run short.
  initial
  begin
    #20000;
    error_cnt++;
    conclude();
  end
  // Main sequence of register, transfer, block and state-bit scenarios.
  initial
  begin
    {p, i_resetn, i_vector_bit0, i_target_bit0, i_xfer_next_reg} = '0;
    {i_cond_state, i_stacked_word, i_move_wdata} = '0;
    cyc(2);
    i_resetn = 1'b1;
    check(o_stack_word, 32'h0100_0000);
    i_move_wdata = 32'h0700_fc00;
    fire(b(MWR));
    check(o_move_rdata, 32'h0);
    check(o_stack_word, 32'h0100_0000);
    fire(b(SAT));
    cyc(3);
    check(o_move_rdata, 32'h0800_0000);
    i_move_wdata = 32'h0;
    fire(b(MWR));
    check(32'(o_sat_flag), 32'h0);
    fire(b(SAT) | b(MWR));
    check(32'(o_sat_flag), 32'h1);
    i_xfer_next_reg = 4'hc;
    fire(b(SUS));
    check({27'h0, o_resume_pending, o_resume_reg}, 32'h1c);
    check(o_stack_word, 32'h0100_c000);
    check(o_move_rdata, 32'h0800_0000);
    fire(b(ENT));
    check(o_stack_word, 32'h0100_0000);
    i_stacked_word = 32'h0100_c000;
    fire(b(RET));
    check({27'h0, o_resume_pending, o_resume_reg}, 32'h1c);
    fire(b(DON));
    check(32'(o_resume_pending), 32'h0);
    i_cond_state = 8'h11;
    fire(b(CST));
    check({27'h0, o_cond_active, o_cond_code}, 32'h11);
    check(o_stack_word, 32'h0300_1000);
    fire(b(RTR));
    fire(b(RTR));
    check(32'(o_cond_active), 32'h1);
    fire(b(RTR));
    fire(b(RTR));
    check(32'(o_cond_active), 32'h0);
    fire(b(BXC));
    check(o_stack_word, 32'h0);
    fire(b(EXA));
    check(32'(o_isa_fault), 32'h1);
    cyc(1);
    check(32'(o_isa_fault), 32'h0);
    i_stacked_word = 32'h0100_0000;
    fire(b(RET));
    check(32'(o_isa_state), 32'h1);
    fire(b(EXA));
    check(32'(o_isa_fault), 32'h0);
    fire(b(BXC));
    i_vector_bit0 = 1'b1;
    fire(b(VEC) | b(BXC));
    check(32'(o_isa_state), 32'h1);
    i_vector_bit0 = 1'b0;
    fire(b(VEC));
    check(32'(o_isa_state), 32'h0);
    i_resetn = 1'b0;
    cyc(1);
    i_resetn = 1'b1;
    check(o_stack_word, 32'h0100_0000);
    conclude();
  end
endmodule
`default_nettype wire
